// [verilog/ddr_burst4_common_io_sram_port.sv]
// burst-of-four ddr common-io sram port, sampled on the system clock
//
// Functional notes
// [R1] operations start on input clock rising edge
// [R2] commands accepted only every second rising edge
// [R3] address and controls captured each rising edge
// [R4] beats one and three taken on rising edge
// [R5] beats two and four taken on complementary edge
// [R6] only unmasked byte lanes of a beat update
// [R7] first write beat one cycle after command
// [R8] second beat on following complementary edge
// [R9] write finishes within two input cycles
// [R10] beats one, three on output-comp edges two, three
// [R11] beats two, four on output-true edges three, four
// [R12] output clocks both high: time from inputs
// [R13] read delivers four beats in two cycles
// [R14] every burst is exactly four beats
// [R15] drive data bus only during read beats
// [R16] echo clocks accompany read data edges
// [R17] loop bypassed: alternate, shorter read latency
// [R18] echo clocks keep running while bus released
// [R19] controller: load low starts op, high reads
// [R20] reads see the latest buffered write data
`timescale 1ns/100ps
module ddr_burst4_common_io_sram_port
  import sram_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic out_clk,
  input wire logic out_clk_n,
  input wire logic dll_bypass_n,
  input wire logic load_select_n,
  input wire logic read_write_sel,
  input wire logic [ADDR_W-1:0] burst_address,
  input wire logic byte_write_mask_n_0,
  input wire logic byte_write_mask_n_1,
  input wire logic byte_write_mask_n_2,
  input wire logic byte_write_mask_n_3,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic echo_clk_true,
  output logic echo_clk_comp
);
  // ****************************************
  // pin sampling and edge detection
  // ****************************************
  logic [PIN_W-1:0] pin_q;
  logic s_k, s_kn, s_c, s_cn, s_loop, s_ld_n, s_rw;
  logic [ADDR_W-1:0] s_addr;
  logic [LANES-1:0] s_mask_n;
  logic [DATA_W-1:0] s_dq;

  pin_sync #(
    .W(PIN_W)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .d({k_clk, k_clk_n, out_clk, out_clk_n, dll_bypass_n, load_select_n, read_write_sel, burst_address,
        byte_write_mask_n_3, byte_write_mask_n_2, byte_write_mask_n_1, byte_write_mask_n_0, dq_in}),
    .q(pin_q)
  );

  assign {s_k, s_kn, s_c, s_cn, s_loop, s_ld_n, s_rw, s_addr, s_mask_n, s_dq} = pin_q;

  logic k_prev_reg, kn_prev_reg, c_prev_reg, cn_prev_reg;
  logic k_prev_next, kn_prev_next, c_prev_next, cn_prev_next;
  logic cmd_last_reg, cmd_last_next;
  logic self_mode_reg, self_mode_next;
  logic [HOLD_W-1:0] hold_cnt_reg, hold_cnt_next;
  logic k_rise, kn_rise, c_rise, cn_rise;
  logic in_edge, out_true_rise, out_comp_rise, out_edge;
  logic cmd, wr_cmd, rd_cmd;

  assign k_rise = s_k & ~k_prev_reg;
  assign kn_rise = s_kn & ~kn_prev_reg;
  assign c_rise = s_c & ~c_prev_reg;
  assign cn_rise = s_cn & ~cn_prev_reg;
  assign in_edge = k_rise | kn_rise;
  // output timing falls back to the input pair once both output clocks have sat high for SELF_HOLD_CNT cycles
  assign out_true_rise = self_mode_reg ? k_rise : c_rise; // [R12]
  assign out_comp_rise = self_mode_reg ? kn_rise : cn_rise; // [R12]
  assign out_edge = out_true_rise | out_comp_rise;
  // a command on the edge right after an accepted one is ignored
  assign cmd = k_rise & ~s_ld_n & ~cmd_last_reg; // [R1] [R2] [R3]
  assign wr_cmd = cmd & ~s_rw;
  assign rd_cmd = cmd & s_rw;

  always_comb begin
    k_prev_next = s_k;
    kn_prev_next = s_kn;
    c_prev_next = s_c;
    cn_prev_next = s_cn;
    cmd_last_next = k_rise ? cmd : cmd_last_reg; // [R2]
    hold_cnt_next = hold_cnt_reg;
    self_mode_next = self_mode_reg;
    if (s_c && s_cn) begin
      if (hold_cnt_reg == SELF_HOLD_CNT) begin
        self_mode_next = 1'b1; // [R12]
      end else begin
        hold_cnt_next = hold_cnt_reg + 1'b1;
      end
    end else begin
      hold_cnt_next = '0;
      self_mode_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      k_prev_reg <= 1'b0;
      kn_prev_reg <= 1'b0;
      c_prev_reg <= 1'b0;
      cn_prev_reg <= 1'b0;
      cmd_last_reg <= 1'b0;
      hold_cnt_reg <= '0;
      self_mode_reg <= 1'b0;
    end else begin
      k_prev_reg <= k_prev_next;
      kn_prev_reg <= kn_prev_next;
      c_prev_reg <= c_prev_next;
      cn_prev_reg <= cn_prev_next;
      cmd_last_reg <= cmd_last_next;
      hold_cnt_reg <= hold_cnt_next;
      self_mode_reg <= self_mode_next;
    end
  end

  // ****************************************
  // write buffer: beats indexed by coming input edges
  // ****************************************
  logic [SCHED_LEN-1:0] wv_reg, wv_next;
  logic [ADDR_W-1:0] wa_reg [SCHED_LEN];
  logic [ADDR_W-1:0] wa_next [SCHED_LEN];
  logic [BEAT_W-1:0] wb_reg [SCHED_LEN];
  logic [BEAT_W-1:0] wb_next [SCHED_LEN];

  always_comb begin
    wv_next = wv_reg;
    wa_next = wa_reg;
    wb_next = wb_reg;
    if (in_edge) begin
      for (int j = 0; j < SCHED_LEN - 1; j++) begin
        wv_next[j] = wv_reg[j+1];
        wa_next[j] = wa_reg[j+1];
        wb_next[j] = wb_reg[j+1];
      end
      wv_next[SCHED_LEN-1] = 1'b0;
    end
    // beat 0 lands one input cycle after the command, the rest on each following edge
    if (wr_cmd) begin
      for (int b = 0; b < BURST_LEN; b++) begin
        wv_next[WR_FIRST_SLOT+b] = 1'b1; // [R7] [R8] [R9] [R14]
        wa_next[WR_FIRST_SLOT+b] = s_addr;
        wb_next[WR_FIRST_SLOT+b] = BEAT_W'(b);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wv_reg <= '0;
      for (int j = 0; j < SCHED_LEN; j++) begin
        wa_reg[j] <= '0;
        wb_reg[j] <= '0;
      end
    end else begin
      wv_reg <= wv_next;
      wa_reg <= wa_next;
      wb_reg <= wb_next;
    end
  end

  // ****************************************
  // read schedule: beats indexed by coming output edges
  // ****************************************
  logic [SCHED_LEN-1:0] rv_reg, rv_next;
  logic [ADDR_W-1:0] ra_reg [SCHED_LEN];
  logic [ADDR_W-1:0] ra_next [SCHED_LEN];
  logic [BEAT_W-1:0] rb_reg [SCHED_LEN];
  logic [BEAT_W-1:0] rb_next [SCHED_LEN];
  int rd_slot;

  // with the loop bypassed the burst starts one output edge earlier
  assign rd_slot = s_loop ? RD_FIRST_SLOT : RD_FIRST_SLOT_DLL_OFF; // [R17]

  always_comb begin
    rv_next = rv_reg;
    ra_next = ra_reg;
    rb_next = rb_reg;
    if (out_edge) begin
      for (int j = 0; j < SCHED_LEN - 1; j++) begin
        rv_next[j] = rv_reg[j+1];
        ra_next[j] = ra_reg[j+1];
        rb_next[j] = rb_reg[j+1];
      end
      rv_next[SCHED_LEN-1] = 1'b0;
    end
    // even beats fall on comp edges, odd beats on true edges; with the loop bypassed, the reverse
    if (rd_cmd) begin
      for (int b = 0; b < BURST_LEN; b++) begin
        rv_next[rd_slot+b] = 1'b1; // [R10] [R11] [R13] [R14]
        ra_next[rd_slot+b] = s_addr;
        rb_next[rd_slot+b] = BEAT_W'(b);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rv_reg <= '0;
      for (int j = 0; j < SCHED_LEN; j++) begin
        ra_reg[j] <= '0;
        rb_reg[j] <= '0;
      end
    end else begin
      rv_reg <= rv_next;
      ra_reg <= ra_next;
      rb_reg <= rb_next;
    end
  end

  // ****************************************
  // array access and write forwarding
  // ****************************************
  logic [LANES-1:0] mem_lanes;
  logic [MEM_AW-1:0] mem_waddr, mem_raddr;
  logic [DATA_W-1:0] mem_q, rd_merged;
  logic [LANES-1:0] fwd_lanes_reg, fwd_lanes_next;
  logic [DATA_W-1:0] fwd_data_reg, fwd_data_next;

  assign mem_lanes = {LANES{in_edge & wv_reg[0]}} & ~s_mask_n; // [R4] [R5] [R6]
  assign mem_waddr = {wa_reg[0], wb_reg[0]};
  assign mem_raddr = {ra_reg[0], rb_reg[0]};

  burst_mem u_mem (
    .clk(clk),
    .lane_we(mem_lanes),
    .waddr(mem_waddr),
    .wdata(s_dq),
    .raddr(mem_raddr),
    .rdata(mem_q)
  );

  // the array reads old data when written in the same cycle, so forward it
  always_comb begin
    fwd_data_next = s_dq;
    fwd_lanes_next = (mem_waddr == mem_raddr) ? mem_lanes : '0; // [R20]
  end

  generate
    for (genvar l = 0; l < LANES; l++) begin : g_merge
      assign rd_merged[l*LANE_W +: LANE_W] = fwd_lanes_reg[l] ?
        fwd_data_reg[l*LANE_W +: LANE_W] : mem_q[l*LANE_W +: LANE_W]; // [R20]
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwd_lanes_reg <= '0;
      fwd_data_reg <= '0;
    end else begin
      fwd_lanes_reg <= fwd_lanes_next;
      fwd_data_reg <= fwd_data_next;
    end
  end

  // ****************************************
  // data bus and echo clocks
  // ****************************************
  logic [DATA_W-1:0] dq_out_next;
  logic dq_oe_next, echo_true_next, echo_comp_next;

  always_comb begin
    dq_out_next = dq_out;
    dq_oe_next = dq_oe;
    echo_true_next = echo_clk_true;
    echo_comp_next = echo_clk_comp;
    if (out_edge) begin
      dq_oe_next = rv_reg[0]; // [R15]
      if (rv_reg[0]) begin
        dq_out_next = rd_merged;
      end
    end
    // echoes follow the output timing edges whether or not data is driven
    if (out_true_rise) begin
      echo_true_next = 1'b1; // [R16] [R18]
      echo_comp_next = 1'b0;
    end else if (out_comp_rise) begin
      echo_true_next = 1'b0; // [R16] [R18]
      echo_comp_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_out <= '0;
      dq_oe <= 1'b0;
      echo_clk_true <= ECHO_TRUE_RST;
      echo_clk_comp <= ECHO_COMP_RST;
    end else begin
      dq_out <= dq_out_next;
      dq_oe <= dq_oe_next;
      echo_clk_true <= echo_true_next;
      echo_clk_comp <= echo_comp_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_cmd_alternate: assert property (@(posedge clk) disable iff (rst) // [R2]
    (k_rise && cmd_last_reg) |-> !cmd)
    else $error("command accepted on back-to-back edges");

  a_wr_buffer_load: assert property (@(posedge clk) disable iff (rst) // [R7]
    wr_cmd |=> wv_reg[WR_FIRST_SLOT] && wv_reg[WR_FIRST_SLOT+3] && (wa_reg[WR_FIRST_SLOT] == $past(s_addr)))
    else $error("write burst not buffered with its address");

  a_wr_lane_mask: assert property (@(posedge clk) disable iff (rst) // [R6]
    (in_edge && wv_reg[0]) |-> (mem_lanes == ~s_mask_n))
    else $error("write lanes differ from the byte mask");

  a_wr_on_edge: assert property (@(posedge clk) disable iff (rst) // [R4]
    (|mem_lanes) |-> (in_edge && wv_reg[0] && (k_rise == (wb_reg[0][0] == 1'b0))))
    else $error("write beat taken on the wrong edge");

  a_rd_latency: assert property (@(posedge clk) disable iff (rst) // [R10]
    (rd_cmd && s_loop) |=> rv_reg[2] && rv_reg[5] && !rv_reg[1] && (rb_reg[2] == '0))
    else $error("read burst scheduled at the wrong latency");

  a_rd_latency_off: assert property (@(posedge clk) disable iff (rst) // [R17]
    (rd_cmd && !s_loop) |=> rv_reg[1] && rv_reg[4] && !rv_reg[5])
    else $error("bypass read latency wrong");

  a_dq_drive: assert property (@(posedge clk) disable iff (rst) // [R15]
    out_edge |=> (dq_oe == $past(rv_reg[0])))
    else $error("data bus drive does not match read beats");

  a_echo_true: assert property (@(posedge clk) disable iff (rst) // [R16]
    out_true_rise |=> echo_clk_true && !echo_clk_comp)
    else $error("true echo missed its edge");

  a_echo_comp: assert property (@(posedge clk) disable iff (rst) // [R18]
    (out_comp_rise && !out_true_rise) |=> !echo_clk_true && echo_clk_comp)
    else $error("comp echo missed its edge");

  a_self_mode: assert property (@(posedge clk) disable iff (rst) // [R12]
    (!s_c || !s_cn) |=> !self_mode_reg)
    else $error("self timing kept with output clocks running");
endmodule

// [verilog/sram_port_pkg.sv]
// shared constants for the burst-of-four common-io sram port
package sram_port_pkg;
  // ****************************************
  // geometry
  // ****************************************
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int BURST_LEN = 4;
  localparam int BEAT_W = 2;
  localparam int MEM_AW = ADDR_W + BEAT_W;
  localparam int PIN_W = 7 + ADDR_W + LANES + DATA_W;

  // ****************************************
  // beat schedules, counted in link edges
  // ****************************************
  localparam int SCHED_LEN = 6;
  localparam int WR_FIRST_SLOT = 1;
  localparam int RD_FIRST_SLOT = 2;
  localparam int RD_FIRST_SLOT_DLL_OFF = 1;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SELF_HOLD_NS = 200;
  localparam int SELF_HOLD_CYC = (SELF_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_W = 6;
  localparam logic [HOLD_W-1:0] SELF_HOLD_CNT = HOLD_W'(SELF_HOLD_CYC);

  // ****************************************
  // reset values
  // ****************************************
  localparam logic ECHO_TRUE_RST = 1'b0;
  localparam logic ECHO_COMP_RST = 1'b1;
endpackage

// [verilog/pin_sync.sv]
// two-flop synchroniser for a group of pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// [verilog/burst_mem.sv]
// byte-lane array with registered read data
`timescale 1ns/100ps
module burst_mem
  import sram_port_pkg::*;
(
  input wire logic clk,
  input wire logic [LANES-1:0] lane_we,
  input wire logic [MEM_AW-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [MEM_AW-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);
  // ****************************************
  // one array per byte lane
  // ****************************************
  generate
    for (genvar l = 0; l < LANES; l++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [2**MEM_AW];
      logic [LANE_W-1:0] lane_q_reg;

      always_ff @(posedge clk) begin
        if (lane_we[l]) begin
          lane_mem[waddr] <= wdata[l*LANE_W +: LANE_W];
        end
        lane_q_reg <= lane_mem[raddr];
      end

      assign rdata[l*LANE_W +: LANE_W] = lane_q_reg;
    end
  endgenerate
endmodule

// [test/sram_ctrl_model.sv]
// controller model: link clocks, commands and write beats
`timescale 1ns/100ps
module sram_ctrl_model
  import sram_port_pkg::*;
(
  input wire logic clk,
  input wire logic self_mode,
  output logic k_clk,
  output logic k_clk_n,
  output logic out_clk,
  output logic out_clk_n,
  output logic load_select_n,
  output logic read_write_sel,
  output logic [ADDR_W-1:0] burst_address,
  output logic [LANES-1:0] mask_n,
  output logic [DATA_W-1:0] ctrl_dq,
  output logic ctrl_oe
);
  logic [4:0] phase = 5'h1F;
  logic [DATA_W-1:0] noise = '0;
  logic [DATA_W-1:0] beat_d = '0;
  logic [LANES-1:0] beat_m = '0;
  initial begin
    {k_clk, k_clk_n, out_clk, out_clk_n} = 4'h5;
    load_select_n = 1'b1;
    read_write_sel = 1'b0;
    burst_address = '0;
    ctrl_oe = 1'b0;
  end
  // a released bus shows a fresh pattern every cycle
  assign ctrl_dq = ctrl_oe ? beat_d : noise;
  assign mask_n = ctrl_oe ? beat_m : noise[LANES-1:0];
  // free-running pairs, output pair held high in self mode
  always @(posedge clk) begin
    #1;
    phase = phase + 5'h01;
    noise = DATA_W'({$urandom, $urandom});
    k_clk = (phase < 5'h10);
    k_clk_n = ~k_clk;
    out_clk = self_mode | k_clk;
    out_clk_n = self_mode | k_clk_n;
  end
  // returns as k falls and k_clk_n rises, half a period clear of each k rise
  task automatic to_fall();
    do @(posedge clk); while (phase != 5'h0F);
    #1;
  endtask
  task automatic send_beats(input logic [3:0][DATA_W-1:0] d, input logic [3:0][LANES-1:0] m);
    repeat (40) @(posedge clk);
    #1;
    ctrl_oe = 1'b1;
    for (int b = 0; b < BURST_LEN; b++) begin
      beat_d = d[b];
      beat_m = m[b];
      repeat ((b == 3) ? 15 : 16) @(posedge clk);
      #1;
    end
    ctrl_oe = 1'b0;
  endtask
  // dbl keeps load low one more rise, with a read that must be ignored
  task automatic issue(input logic rd, input logic [ADDR_W-1:0] a, input logic [3:0][DATA_W-1:0] d,
                       input logic [3:0][LANES-1:0] m, input logic dbl);
    to_fall();
    load_select_n = 1'b0;
    read_write_sel = rd;
    burst_address = a;
    if (!rd) begin
      fork
        send_beats(d, m);
      join_none
    end
    to_fall();
    if (dbl) begin
      read_write_sel = 1'b1;
      burst_address = ~a;
      to_fall();
    end
    load_select_n = 1'b1;
    read_write_sel = 1'($urandom);
    burst_address = ADDR_W'($urandom);
  endtask
endmodule

// [test/tb_ddr_burst4_common_io_sram_port.sv]
// self-checking bench for the burst-of-four sram port
`timescale 1ns/100ps
module tb_ddr_burst4_common_io_sram_port
  import sram_port_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dll_bypass_n = 1'b1;
  logic self_mode = 1'b0;
  logic k_clk, k_clk_n, out_clk, out_clk_n, load_select_n, read_write_sel;
  logic dq_oe, echo_clk_true, echo_clk_comp, ctrl_oe;
  logic echo_seen = 1'b0;
  logic [ADDR_W-1:0] burst_address, a;
  logic [LANES-1:0] mask_n;
  logic [3:0][LANES-1:0] m;
  logic [DATA_W-1:0] dq_in, dq_out, ctrl_dq;
  logic [DATA_W-1:0] mem [int];
  int bad_count = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  assign dq_in = dq_oe ? dq_out : ctrl_dq;
  ddr_burst4_common_io_sram_port dut (.clk(clk), .rst(rst), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .out_clk(out_clk), .out_clk_n(out_clk_n), .dll_bypass_n(dll_bypass_n), .load_select_n(load_select_n),
    .read_write_sel(read_write_sel), .burst_address(burst_address), .byte_write_mask_n_0(mask_n[0]),
    .byte_write_mask_n_1(mask_n[1]), .byte_write_mask_n_2(mask_n[2]), .byte_write_mask_n_3(mask_n[3]),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .echo_clk_true(echo_clk_true), .echo_clk_comp(echo_clk_comp));
  sram_ctrl_model ctrl (.clk(clk), .self_mode(self_mode), .k_clk(k_clk), .k_clk_n(k_clk_n), .out_clk(out_clk),
    .out_clk_n(out_clk_n), .load_select_n(load_select_n), .read_write_sel(read_write_sel),
    .burst_address(burst_address), .mask_n(mask_n), .ctrl_dq(ctrl_dq), .ctrl_oe(ctrl_oe));
  task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (dq_oe === 1'b1 && ctrl_oe === 1'b1) check("bus contention", '0, '1);
  end
  task automatic next_edge();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #2;
      n++;
    end while (echo_clk_true === echo_seen && n < 40);
    check("echo toggle", DATA_W'(1), DATA_W'(n < 40));
    check("echo pair", DATA_W'(1), DATA_W'(echo_clk_true ^ echo_clk_comp));
    echo_seen = echo_clk_true;
  endtask
  task automatic do_write(input logic [ADDR_W-1:0] wa, input logic [3:0][LANES-1:0] wm, input logic dbl);
    logic [3:0][DATA_W-1:0] d;
    for (int b = 0; b < BURST_LEN; b++) begin
      d[b] = DATA_W'({$urandom, $urandom});
      for (int l = 0; l < LANES; l++)
        if (!wm[b][l]) mem[{wa, 2'(b)}][l*LANE_W +: LANE_W] = d[b][l*LANE_W +: LANE_W];
    end
    ctrl.issue(1'b0, wa, d, wm, dbl);
  endtask
  task automatic do_read(input logic [ADDR_W-1:0] ra, input int lat);
    int n;
    ctrl.issue(1'b1, ra, '0, '0, 1'b0);
    echo_seen = echo_clk_true;
    n = 0;
    do begin
      next_edge();
      n++;
    end while (dq_oe !== 1'b1 && n < 8);
    check("read latency", DATA_W'(lat), DATA_W'(n));
    for (int b = 0; b < BURST_LEN; b++) begin
      if (b > 0) next_edge();
      check("read oe", DATA_W'(1), DATA_W'(dq_oe));
      check("read beat", mem[{ra, 2'(b)}], dq_out);
    end
    next_edge();
    check("release oe", '0, DATA_W'(dq_oe));
  endtask
  task automatic idle_echo();
    int t;
    t = 0;
    echo_seen = echo_clk_true;
    repeat (64) begin
      @(posedge clk);
      #2;
      if (echo_clk_true !== echo_seen) t++;
      echo_seen = echo_clk_true;
      check("idle oe", '0, DATA_W'(dq_oe));
    end
    check("idle echo edges", DATA_W'(4), DATA_W'(t));
  endtask
  initial begin
    void'($urandom(32'h296A));
    repeat (10) @(posedge clk);
    check("reset oe", '0, DATA_W'(dq_oe));
    check("reset echo", DATA_W'(2'b01), DATA_W'({echo_clk_true, echo_clk_comp}));
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    idle_echo();
    for (int i = 0; i < 6; i++) begin
      a = ADDR_W'($urandom);
      do_write(a, '0, 1'b0);
      m = (i == 0) ? '1 : 16'($urandom);
      do_write(a, m, 1'b0);
      do_read(a, 3);
    end
    a = ADDR_W'($urandom);
    do_write(a, '0, 1'b1);
    idle_echo();
    do_read(a, 3);
    @(posedge clk);
    #1;
    dll_bypass_n = 1'b0;
    repeat (8) @(posedge clk);
    do_read(a, 2);
    @(posedge clk);
    #1;
    dll_bypass_n = 1'b1;
    self_mode = 1'b1;
    repeat (64) @(posedge clk);
    idle_echo();
    do_read(a, 3);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("CHECK FAILED watchdog expected done seen hang");
    finish_test();
  end
endmodule
